//--- timer_pkg.sv
// constants for the split and capture timer block
package timer_pkg;
   // register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] MASK_OFS = 8'h08;
   localparam logic [7:0] COUNT_OFS = 8'h0c;
   localparam logic [7:0] RELOAD_OFS = 8'h10;
   // control register field positions
   localparam int RUN_BIT = 0;
   localparam int SPLIT_BIT = 1;
   localparam int CAPEN_BIT = 2;
   localparam int LOWIE_BIT = 3;
   localparam int SRC_LO_BIT = 4;
   localparam int SRC_HI_BIT = 5;
   localparam int HSEL_BIT = 6;
   localparam int LSEL_BIT = 7;
   localparam int TIE_BIT = 8;
   localparam int CTRL_W = 9;
   // status and mask field positions
   localparam int HFLAG_BIT = 0;
   localparam int LFLAG_BIT = 1;
   // reset values
   localparam logic [8:0] CTRL_RST = 9'h000;
   localparam logic [1:0] MASK_RST = 2'h3;
   localparam logic [15:0] COUNT_RST = 16'h0000;
   localparam logic [15:0] RELOAD_RST = 16'h0000;
   // external source encodings
   localparam logic [1:0] SRC_SYS12 = 2'h0;
   localparam logic [1:0] SRC_RTC8 = 2'h1;
   localparam logic [1:0] SRC_RSVD = 2'h2;
   localparam logic [1:0] SRC_CMP = 2'h3;
   // prescaler counts
   localparam logic [3:0] SYS_DIV = 4'hc;
   localparam logic [2:0] RTC_DIV_LAST = 3'h7;
   // byte roll-over point
   localparam logic [7:0] BYTE_MAX = 8'hff;
   // bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- tick_if.sv
// tick strobes passed from the prescaler to the timer core
`timescale 1ns/1ps
`default_nettype none
interface tick_if;
   logic sys12; // system clock divided by 12
   logic rtc8; // every eighth real-time clock rise
   logic cmp_rise; // comparator 0 rising edge
   modport src (output sys12, output rtc8, output cmp_rise);
   modport dst (input sys12, input rtc8, input cmp_rise);
endinterface
`default_nettype wire

//--- timer_tick_gen.sv
// prescaler and edge detectors producing one-cycle tick enables
`timescale 1ns/1ps
`default_nettype none
module timer_tick_gen (
   input wire logic clk_in, // system clock
   input wire logic rst_n_in, // async reset, active low
   input wire logic rtc_in, // real-time clock level, synchronous
   input wire logic cmp_in, // comparator 0 output, synchronous
   tick_if.src ticks // tick strobes out
);
   logic [3:0] div12;
   logic [2:0] rtc_cnt;
   logic rtc_d;
   logic cmp_d;

   // ----------------------------------------
   // divide by 12
   // ----------------------------------------
   // terminal count gives one enable pulse every twelve system clocks
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         div12 <= 4'h0;
         ticks.sys12 <= 1'b0;
      end else begin
         ticks.sys12 <= (div12 == timer_pkg::SYS_DIV - 4'h1);
         div12 <= (div12 == timer_pkg::SYS_DIV - 4'h1) ? 4'h0 : div12 + 4'h1;
      end
   end

   // ----------------------------------------
   // real-time clock and comparator edges
   // ----------------------------------------
   // inputs are synchronous, so one delay stage is enough for the edge
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rtc_d <= 1'b0;
         cmp_d <= 1'b0;
         rtc_cnt <= 3'h0;
         ticks.rtc8 <= 1'b0;
         ticks.cmp_rise <= 1'b0;
      end else begin
         rtc_d <= rtc_in;
         cmp_d <= cmp_in;
         ticks.cmp_rise <= cmp_in & ~cmp_d;
         ticks.rtc8 <= rtc_in & ~rtc_d & (rtc_cnt == timer_pkg::RTC_DIV_LAST);
         if (rtc_in & ~rtc_d) begin
            rtc_cnt <= rtc_cnt + 3'h1; // wraps after eight rises
         end
      end
   end
endmodule
`default_nettype wire

//--- timer_split_capture.sv
// split 8-bit / 16-bit auto-reload timer with capture, AXI4-Lite slave
// Notes on behaviour
// RULE_01: split mode runs two 8-bit halves, each reloading on overflow.
// RULE_02: low reload feeds low half, high reload feeds high half.
// RULE_03: run control gates only the high half; low half always counts in split.
// RULE_04: clock select set picks system clock, else source field chooses the clock.
// RULE_05: halves have own clock-select bits and share the source field.
// RULE_06: high and low flags set on their half rolling 0xff to 0x00.
// RULE_07: with timer interrupt enabled, each high overflow requests interrupt.
// RULE_08: with low interrupt enable too, either overflow requests interrupt.
// RULE_09: hardware never clears the flags; software clears and inspects both.
// RULE_10: software sets capture enable and should use 16-bit auto-reload mode.
// RULE_11: capture on comparator rise or every 8 real-time clocks, per upper bit.
// RULE_12: capture copies the 16-bit count to reload and sets the high flag.
// RULE_13: upper bit 0 captures on real-time clock / 8; count keeps its clock.
// RULE_14: upper bit 1 captures on comparator rise; reserved code never ticks.
`timescale 1ns/1ps
`default_nettype none
module timer_split_capture (
   input wire logic CLK_IN, // 125 MHz system clock
   input wire logic RST_N_IN, // async reset, active low
   input wire logic RTC_IN, // real-time clock level
   input wire logic CMP0_IN, // comparator 0 output
   input wire logic AWVALID_IN, // write address valid
   output logic AWREADY_OUT, // write address ready
   input wire logic [31:0] AWADDR_IN, // write address
   input wire logic WVALID_IN, // write data valid
   output logic WREADY_OUT, // write data ready
   input wire logic [31:0] WDATA_IN, // write data
   input wire logic [3:0] WSTRB_IN, // write byte lanes
   output logic BVALID_OUT, // write response valid
   input wire logic BREADY_IN, // write response ready
   output logic [1:0] BRESP_OUT, // write response code
   input wire logic ARVALID_IN, // read address valid
   output logic ARREADY_OUT, // read address ready
   input wire logic [31:0] ARADDR_IN, // read address
   output logic RVALID_OUT, // read data valid
   input wire logic RREADY_IN, // read data ready
   output logic [31:0] RDATA_OUT, // read data
   output logic [1:0] RRESP_OUT, // read response code
   output logic IRQ_OUT // level interrupt, active high
);
   tick_if ticks ();
   logic [8:0] ctrl;
   logic [1:0] status;
   logic [1:0] mask;
   logic [15:0] count;
   logic [15:0] reload;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic aw_got;
   logic w_got;
   logic do_wr;
   logic wr_hit;
   logic rd_hit;
   logic [31:0] rd_word;
   logic tick_l;
   logic tick_h;
   logic cap_evt;
   logic ovf_l;
   logic ovf_h;
   logic [15:0] next_count;
   logic [1:0] irq_src;
   // per-register write strobes and merged write words
   logic [31:0] ctrl_m;
   logic [31:0] count_m;
   logic [31:0] reload_m;
   logic wr_ctrl;
   logic wr_status;
   logic wr_mask;
   logic wr_count;
   logic wr_reload;
   logic clr_h;
   logic clr_l;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // selected tick for one half; reserved code yields no tick
   function automatic logic pick_tick(input logic use_sys, input logic [1:0] src,
                                      input logic t12, input logic t8, input logic tc);
      logic t;
      t = 1'b0;
      if (use_sys) begin
         t = 1'b1; // RULE_04
      end else begin
         unique case (src)
            timer_pkg::SRC_SYS12: t = t12;
            timer_pkg::SRC_RTC8: t = t8;
            timer_pkg::SRC_RSVD: t = 1'b0; // RULE_14
            timer_pkg::SRC_CMP: t = tc;
         endcase
      end
      return t;
   endfunction

   // byte-lane merge of a write into a register word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            r[8*i +: 8] = d[8*i +: 8];
         end
      end
      return r;
   endfunction

   // ----------------------------------------
   // tick sources
   // ----------------------------------------
   timer_tick_gen u_ticks (
      .clk_in(CLK_IN),
      .rst_n_in(RST_N_IN),
      .rtc_in(RTC_IN),
      .cmp_in(CMP0_IN),
      .ticks(ticks.src)
   );

   // each half picks its own clock from the shared source field
   // both halves share the field, so only one external source serves at a time
   assign tick_l = pick_tick(ctrl[timer_pkg::LSEL_BIT], // RULE_05
                             ctrl[timer_pkg::SRC_HI_BIT:timer_pkg::SRC_LO_BIT],
                             ticks.sys12, ticks.rtc8, ticks.cmp_rise);
   assign tick_h = pick_tick(ctrl[timer_pkg::HSEL_BIT], // RULE_05
                             ctrl[timer_pkg::SRC_HI_BIT:timer_pkg::SRC_LO_BIT],
                             ticks.sys12, ticks.rtc8, ticks.cmp_rise);

   // capture source follows only the upper source bit
   assign cap_evt = ctrl[timer_pkg::CAPEN_BIT] & // RULE_11
                    (ctrl[timer_pkg::SRC_HI_BIT] ? ticks.cmp_rise : ticks.rtc8); // RULE_13 RULE_14

   // ----------------------------------------
   // counter next state
   // ----------------------------------------
   // split mode: independent bytes; otherwise one 16-bit reload counter
   // capture is meant for 16-bit mode, but split mode still takes the snapshot
   always_comb begin
      next_count = count;
      ovf_l = 1'b0;
      ovf_h = 1'b0;
      if (ctrl[timer_pkg::SPLIT_BIT]) begin
         if (tick_l) begin // RULE_03
            ovf_l = (count[7:0] == timer_pkg::BYTE_MAX); // RULE_06
            next_count[7:0] = ovf_l ? reload[7:0] : count[7:0] + 8'h01; // RULE_01 RULE_02
         end
         if (tick_h && ctrl[timer_pkg::RUN_BIT]) begin // RULE_03
            ovf_h = (count[15:8] == timer_pkg::BYTE_MAX); // RULE_06
            next_count[15:8] = ovf_h ? reload[15:8] : count[15:8] + 8'h01; // RULE_01 RULE_02
         end
      end else if (tick_l && ctrl[timer_pkg::RUN_BIT]) begin
         ovf_l = (count[7:0] == timer_pkg::BYTE_MAX);
         ovf_h = (count == 16'hffff);
         next_count = ovf_h ? reload : count + 16'h0001;
      end
   end

   // ----------------------------------------
   // bus write channels
   // ----------------------------------------
   // address and data are taken in either order; the write fires once both are held
   assign do_wr = aw_got & w_got & ~BVALID_OUT;

   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         AWREADY_OUT <= 1'b1;
         aw_got <= 1'b0;
         aw_addr <= 8'h00;
      end else if (AWREADY_OUT && AWVALID_IN) begin
         AWREADY_OUT <= 1'b0;
         aw_got <= 1'b1;
         // anything above the map folds onto an unmapped offset, so it answers an error
         aw_addr <= (AWADDR_IN[31:8] == 24'h000000) ? AWADDR_IN[7:0] : 8'hff;
      end else if (BVALID_OUT && BREADY_IN) begin
         AWREADY_OUT <= 1'b1;
         aw_got <= 1'b0;
      end
   end

   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         WREADY_OUT <= 1'b1;
         w_got <= 1'b0;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
      end else if (WREADY_OUT && WVALID_IN) begin
         WREADY_OUT <= 1'b0;
         w_got <= 1'b1;
         w_data <= WDATA_IN;
         w_strb <= WSTRB_IN;
      end else if (BVALID_OUT && BREADY_IN) begin
         WREADY_OUT <= 1'b1;
         w_got <= 1'b0;
      end
   end

   // address decode for writes; upper address bits must be zero to hit
   always_comb begin
      unique case (aw_addr)
         timer_pkg::CTRL_OFS, timer_pkg::STATUS_OFS, timer_pkg::MASK_OFS,
         timer_pkg::COUNT_OFS, timer_pkg::RELOAD_OFS: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   // one strobe per register; a missed address leaves every register untouched
   assign wr_ctrl = do_wr && aw_addr == timer_pkg::CTRL_OFS;
   assign wr_status = do_wr && aw_addr == timer_pkg::STATUS_OFS && w_strb[0];
   assign wr_mask = do_wr && aw_addr == timer_pkg::MASK_OFS && w_strb[0];
   assign wr_count = do_wr && aw_addr == timer_pkg::COUNT_OFS;
   assign wr_reload = do_wr && aw_addr == timer_pkg::RELOAD_OFS;
   // write-one-clear requests for the two flags
   assign clr_h = wr_status && w_data[timer_pkg::HFLAG_BIT];
   assign clr_l = wr_status && w_data[timer_pkg::LFLAG_BIT];

   // merged words are kept whole here, so the registers take a plain part-select
   assign ctrl_m = merge({23'h000000, ctrl}, w_data, w_strb);
   assign count_m = merge({16'h0000, count}, w_data, w_strb);
   assign reload_m = merge({16'h0000, reload}, w_data, w_strb);

   // response one cycle after both halves of the write are held
   // error writes still answer, so a master never hangs on a bad address
   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         BVALID_OUT <= 1'b0;
         BRESP_OUT <= timer_pkg::RESP_OKAY;
      end else if (do_wr) begin
         BVALID_OUT <= 1'b1;
         BRESP_OUT <= wr_hit ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
      end else if (BVALID_OUT && BREADY_IN) begin
         BVALID_OUT <= 1'b0;
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   // control: software steers mode, clocks and run gating
   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         ctrl <= timer_pkg::CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl <= ctrl_m[8:0];
      end
   end

   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         mask <= timer_pkg::MASK_RST;
      end else if (wr_mask) begin
         mask <= w_data[1:0];
      end
   end

   // flags: only a written one clears; a same-cycle event wins over the clear
   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         status <= 2'h0;
      end else begin
         status[timer_pkg::HFLAG_BIT] <= ovf_h | cap_evt | // RULE_06 RULE_12
            (status[timer_pkg::HFLAG_BIT] & ~clr_h); // RULE_09
         status[timer_pkg::LFLAG_BIT] <= ovf_l | // RULE_06
            (status[timer_pkg::LFLAG_BIT] & ~clr_l); // RULE_09
      end
   end

   // counter: a software write takes priority over a tick in the same cycle
   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         count <= timer_pkg::COUNT_RST;
      end else if (wr_count) begin
         count <= count_m[15:0];
      end else begin
         count <= next_count;
      end
   end

   // reload: a capture snapshot beats a software write, so no capture is lost
   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         reload <= timer_pkg::RELOAD_RST;
      end else if (cap_evt) begin
         reload <= count; // RULE_12
      end else if (wr_reload) begin
         reload <= reload_m[15:0];
      end
   end

   // ----------------------------------------
   // interrupt
   // ----------------------------------------
   // low flag only contributes when its own enable is set
   assign irq_src[timer_pkg::HFLAG_BIT] = status[timer_pkg::HFLAG_BIT]; // RULE_07
   assign irq_src[timer_pkg::LFLAG_BIT] = status[timer_pkg::LFLAG_BIT] &
                                          ctrl[timer_pkg::LOWIE_BIT]; // RULE_08

   // registered so the pin never glitches while flags, mask and enables settle
   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         IRQ_OUT <= 1'b0;
      end else begin
         IRQ_OUT <= ctrl[timer_pkg::TIE_BIT] & |(irq_src & mask); // RULE_07 RULE_08
      end
   end

   // ----------------------------------------
   // bus read channel
   // ----------------------------------------
   // read mux on the incoming address; unmapped words read zero with an error
   // decoding the live address lets the data follow the address with no wait state
   always_comb begin
      rd_word = 32'h00000000;
      rd_hit = 1'b1;
      if (ARADDR_IN[31:8] != 24'h000000) begin
         rd_hit = 1'b0;
      end else begin
         unique case (ARADDR_IN[7:0])
            timer_pkg::CTRL_OFS: rd_word = {23'h000000, ctrl};
            timer_pkg::STATUS_OFS: rd_word = {30'h00000000, status};
            timer_pkg::MASK_OFS: rd_word = {30'h00000000, mask};
            timer_pkg::COUNT_OFS: rd_word = {16'h0000, count};
            timer_pkg::RELOAD_OFS: rd_word = {16'h0000, reload};
            default: rd_hit = 1'b0;
         endcase
      end
   end

   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         ARREADY_OUT <= 1'b1;
         RVALID_OUT <= 1'b0;
         RDATA_OUT <= 32'h00000000;
         RRESP_OUT <= timer_pkg::RESP_OKAY;
      end else if (ARREADY_OUT && ARVALID_IN) begin
         ARREADY_OUT <= 1'b0;
         RVALID_OUT <= 1'b1;
         RDATA_OUT <= rd_word;
         RRESP_OUT <= rd_hit ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
      end else if (RVALID_OUT && RREADY_IN) begin
         RVALID_OUT <= 1'b0;
         ARREADY_OUT <= 1'b1;
      end
   end
endmodule
`default_nettype wire

//--- timer_split_capture_chk.sv
// bus handshake and interrupt checker for the split and capture timer
`timescale 1ns/1ps
`default_nettype none
module timer_split_capture_chk (
   input wire logic CLK_IN, // system clock
   input wire logic RST_N_IN, // async reset, active low
   input wire logic AWVALID_IN, // write address valid
   input wire logic AWREADY_OUT, // write address ready
   input wire logic WVALID_IN, // write data valid
   input wire logic WREADY_OUT, // write data ready
   input wire logic BVALID_OUT, // write response valid
   input wire logic BREADY_IN, // write response ready
   input wire logic [1:0] BRESP_OUT, // write response code
   input wire logic ARVALID_IN, // read address valid
   input wire logic ARREADY_OUT, // read address ready
   input wire logic RVALID_OUT, // read data valid
   input wire logic RREADY_IN, // read data ready
   input wire logic [31:0] RDATA_OUT, // read data
   input wire logic [1:0] RRESP_OUT, // read response code
   input wire logic IRQ_OUT // level interrupt
);
   // ----------------------------------------
   // one clock domain, so clocking is shared
   // ----------------------------------------
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (!RST_N_IN);

   // a response must not move until the master has taken it
   bresp_hold_a: assert property (BVALID_OUT && !BREADY_IN |=> BVALID_OUT && $stable(BRESP_OUT))
      else $error("write response dropped or changed");
   rdata_hold_a: assert property (RVALID_OUT && !RREADY_IN
      |=> RVALID_OUT && $stable(RDATA_OUT) && $stable(RRESP_OUT))
      else $error("read data dropped or changed");
   wr_busy_a: assert property (BVALID_OUT |-> !AWREADY_OUT && !WREADY_OUT)
      else $error("write accepted while response pending");
   rd_busy_a: assert property (RVALID_OUT |-> !ARREADY_OUT)
      else $error("read accepted while data pending");
   rd_answer_a: assert property (ARVALID_IN && ARREADY_OUT |=> RVALID_OUT)
      else $error("read answer late");
   wr_answer_a: assert property (AWVALID_IN && AWREADY_OUT && WVALID_IN && WREADY_OUT
      |-> ##[1:2] BVALID_OUT)
      else $error("write answer late");
   ready_back_a: assert property (BVALID_OUT && BREADY_IN |=> AWREADY_OUT && WREADY_OUT && !BVALID_OUT)
      else $error("write channel not reopened");
   resp_code_a: assert property (BVALID_OUT
      |-> BRESP_OUT == timer_pkg::RESP_OKAY || BRESP_OUT == timer_pkg::RESP_SLVERR)
      else $error("illegal write response code");
   // flags only go away by software, so the line only drops around a write
   irq_clear_a: assert property ($fell(IRQ_OUT) |-> BVALID_OUT || $past(BVALID_OUT))
      else $error("interrupt dropped without a write");
endmodule

bind timer_split_capture timer_split_capture_chk chk (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN),
   .AWVALID_IN(AWVALID_IN), .AWREADY_OUT(AWREADY_OUT), .WVALID_IN(WVALID_IN),
   .WREADY_OUT(WREADY_OUT), .BVALID_OUT(BVALID_OUT), .BREADY_IN(BREADY_IN),
   .BRESP_OUT(BRESP_OUT), .ARVALID_IN(ARVALID_IN), .ARREADY_OUT(ARREADY_OUT),
   .RVALID_OUT(RVALID_OUT), .RREADY_IN(RREADY_IN), .RDATA_OUT(RDATA_OUT),
   .RRESP_OUT(RRESP_OUT), .IRQ_OUT(IRQ_OUT));
`default_nettype wire

//--- tb_timer_split_capture.sv
// self-checking bench for the split and capture timer
`timescale 1ns/1ps
`default_nettype none
module tb_timer_split_capture;
   logic clk, rst_n, rtc, cmp0, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [31:0] awaddr, wdata, araddr, rdata, rd_val;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, resp;
   logic [2:0] rtc_div = 3'h0;
   logic [7:0] src_lo [4] = '{8'h07, 8'h01, 8'h00, 8'h04};
   logic [7:0] src_hi [4] = '{8'h0a, 8'h02, 8'h00, 8'h04};
   int n_errors = 0;
   int checked = 0;
   int cyc = 0;

   timer_split_capture dut (.CLK_IN(clk), .RST_N_IN(rst_n), .RTC_IN(rtc), .CMP0_IN(cmp0),
      .AWVALID_IN(awvalid), .AWREADY_OUT(awready), .AWADDR_IN(awaddr), .WVALID_IN(wvalid),
      .WREADY_OUT(wready), .WDATA_IN(wdata), .WSTRB_IN(wstrb), .BVALID_OUT(bvalid),
      .BREADY_IN(bready), .BRESP_OUT(bresp), .ARVALID_IN(arvalid), .ARREADY_OUT(arready),
      .ARADDR_IN(araddr), .RVALID_OUT(rvalid), .RREADY_IN(rready), .RDATA_OUT(rdata),
      .RRESP_OUT(rresp), .IRQ_OUT(irq));

   // -------------------------
   // clock, rtc and watchdog
   // -------------------------
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // real-time clock rises every eight system clocks, so rtc / 8 is every 64
   always @(posedge clk) begin
      rtc_div <= rtc_div + 3'h1;
      rtc <= rtc_div[2];
   end
   // the whole run needs about a thousand cycles; the ceiling leaves ample margin
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         results();
      end
   end

   // -------------------------
   // reporting and bus tasks
   // -------------------------
   task results;
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task rng(input string n, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] g);
      checked++;
      if ((g >= lo && g <= hi) !== 1'b1) begin
         n_errors++;
         $display("ERROR %s expected %h..%h seen %h", n, lo, hi, g);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      awvalid <= 1'b1;
      awaddr <= {24'h0, a};
      wvalid <= 1'b1;
      wdata <= d;
      wstrb <= 4'hf;
      do begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while ((awvalid && !awready) || (wvalid && !wready));
      bready <= 1'b1;
      do @(posedge clk); while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      arvalid <= 1'b1;
      araddr <= {24'h0, a};
      do @(posedge clk); while (!arready);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do @(posedge clk); while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   task wrc(input logic [7:0] a, input logic [31:0] d);
      wr(a, d, resp);
      chk("bresp", {30'h0, timer_pkg::RESP_OKAY}, {30'h0, resp});
   endtask
   task rdc(input string n, input logic [7:0] a, input logic [31:0] e);
      rd(a, rd_val, resp);
      chk(n, e, rd_val);
   endtask
   task waitc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // comparator rises spaced 24 clocks apart, held 12 high
   task pulse_cmp(input int n);
      repeat (n) begin
         @(posedge clk);
         cmp0 <= 1'b1;
         waitc(12);
         cmp0 <= 1'b0;
         waitc(11);
      end
   endtask

   // -------------------------
   // scenarios
   // -------------------------
   task t_reset;
      rdc("ctrl", timer_pkg::CTRL_OFS, 32'h0);
      rdc("status", timer_pkg::STATUS_OFS, 32'h0);
      rdc("mask", timer_pkg::MASK_OFS, 32'h3);
      rdc("count", timer_pkg::COUNT_OFS, 32'h0);
      rdc("reload", timer_pkg::RELOAD_OFS, 32'h0);
      wr(8'h14, 32'hffff_ffff, resp);
      chk("bresp_unmapped", 32'h2, {30'h0, resp});
      rd(8'h14, rd_val, resp);
      chk("rresp_unmapped", 32'h2, {30'h0, resp});
      chk("rdata_unmapped", 32'h0, rd_val);
   endtask
   task t_split;
      wrc(timer_pkg::RELOAD_OFS, 32'h0000_30f0);
      wrc(timer_pkg::COUNT_OFS, 32'h0000_fdfe);
      wrc(timer_pkg::CTRL_OFS, 32'h0000_0082); // low on system clock, run off
      waitc(20);
      rd(timer_pkg::COUNT_OFS, rd_val, resp);
      chk("count_high", 32'hfd, {24'h0, rd_val[15:8]});
      rng("count_low", 32'hf0, 32'hff, {24'h0, rd_val[7:0]});
      rdc("status", timer_pkg::STATUS_OFS, 32'h2);
      wrc(timer_pkg::CTRL_OFS, 32'h0000_00c3);
      waitc(20);
      rd(timer_pkg::COUNT_OFS, rd_val, resp);
      rng("count_high", 32'h30, 32'h50, {24'h0, rd_val[15:8]});
      rdc("status", timer_pkg::STATUS_OFS, 32'h3);
   endtask
   task t_irq;
      wrc(timer_pkg::CTRL_OFS, 32'h0000_0182);
      wrc(timer_pkg::STATUS_OFS, 32'h3);
      waitc(30);
      chk("irq", 32'h0, {31'h0, irq});
      wrc(timer_pkg::CTRL_OFS, 32'h0000_018a);
      waitc(3);
      chk("irq", 32'h1, {31'h0, irq});
      wrc(timer_pkg::CTRL_OFS, 32'h0000_0108); // nothing counts now
      waitc(50);
      rdc("status", timer_pkg::STATUS_OFS, 32'h2);
      wrc(timer_pkg::MASK_OFS, 32'h0);
      waitc(3);
      chk("irq", 32'h0, {31'h0, irq});
      wrc(timer_pkg::MASK_OFS, 32'h3);
      waitc(3);
      chk("irq", 32'h1, {31'h0, irq});
      wrc(timer_pkg::STATUS_OFS, 32'h2);
      rdc("status", timer_pkg::STATUS_OFS, 32'h0);
      chk("irq", 32'h0, {31'h0, irq});
      wrc(timer_pkg::COUNT_OFS, 32'h0000_f000);
      wrc(timer_pkg::CTRL_OFS, 32'h0000_01c3);
      waitc(30);
      chk("irq", 32'h1, {31'h0, irq});
      wrc(timer_pkg::CTRL_OFS, 32'h0);
      wrc(timer_pkg::STATUS_OFS, 32'h3);
   endtask
   // low half walks every source code while high runs on the system clock
   task t_src;
      for (int s = 0; s < 4; s++) begin
         wrc(timer_pkg::CTRL_OFS, 32'h43 | (32'(s) << 4));
         wrc(timer_pkg::COUNT_OFS, 32'h0);
         pulse_cmp(4);
         waitc(6);
         rd(timer_pkg::COUNT_OFS, rd_val, resp);
         rng("count_low", {24'h0, src_lo[s]}, {24'h0, src_hi[s]}, {24'h0, rd_val[7:0]});
         rng("count_high", 32'd96, 32'd130, {24'h0, rd_val[15:8]});
      end
   endtask
   task t_capture;
      wrc(timer_pkg::CTRL_OFS, 32'h0000_01b5); // capture on comparator
      wrc(timer_pkg::STATUS_OFS, 32'h3);
      wrc(timer_pkg::RELOAD_OFS, 32'h0);
      wrc(timer_pkg::COUNT_OFS, 32'h0);
      waitc(150);
      rdc("reload", timer_pkg::RELOAD_OFS, 32'h0);
      rdc("status", timer_pkg::STATUS_OFS, 32'h0);
      pulse_cmp(1);
      rdc("status", timer_pkg::STATUS_OFS, 32'h1);
      chk("irq", 32'h1, {31'h0, irq});
      rd(timer_pkg::RELOAD_OFS, rd_val, resp);
      rng("reload", 32'h90, 32'hd0, rd_val);
      wrc(timer_pkg::CTRL_OFS, 32'h0000_0195); // capture on rtc / 8
      wrc(timer_pkg::STATUS_OFS, 32'h1);
      wrc(timer_pkg::COUNT_OFS, 32'h0);
      waitc(68);
      rdc("status", timer_pkg::STATUS_OFS, 32'h1);
      rd(timer_pkg::RELOAD_OFS, rd_val, resp);
      rng("reload", 32'h0, 32'h48, rd_val);
      wrc(timer_pkg::CTRL_OFS, 32'h0);
   endtask

   // -------------------------
   // main sequence
   // -------------------------
   initial begin
      rst_n = 1'b0;
      cmp0 = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      {awaddr, wdata, araddr} = '0;
      wstrb = 4'h0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_split();
      t_irq();
      t_src();
      t_capture();
      results();
   end
endmodule
`default_nettype wire
